// ---- core/ucil_channel.sv ----
// Operation
// - rx interrupt at trigger, drops below it; with fifo off, any data
// - data ready sets on push, clears empty
// - low mask bits clear gives polled mode
// - line status bits overrun, errors, empties
// - timeout after four chars twelve bits
// - mask bit0 gates rx and timeout
// - mask bit1 transmit, half-duplex picks source
// - mask bit2 line errors interrupt immediately
// - mask bit3 modem delta bits interrupt
// - high mask bits need enhanced enable
// - mask bit6 or bit7 enables rts/dtr output rising
// - mask bit6 or bit7 enables cts/dsr input rising
// - source read shows highest, others wait
// - priority codes for seven sources
// - source bit0 low while pending
// - wake indicator set, cleared by global read
// - line and modem reads clear theirs
// - host drains fifo to clear rx
// - source read clears tx and xon/xoff
// - special char clears on read or next
// - bit4 flags flow char, last one readable
// - pending shown in global word too
// - source bits 7:6 show fifo enable
// - source bit5 handshake rising change
`include "ucil_defines.svh"
module ucil_channel #(
  parameter int FIFO_AW = 7, // fifo level width
  parameter int CHAR_BITS_W = 4, // bits per character width
  parameter int TMO_W = 16 // timeout counter width
) (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic [3:0] reg_addr, // channel register index
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, registered
  input wire logic fifo_en, // fifo control enable bit
  input wire logic rs485_auto, // feature control auto half-duplex
  input wire logic [7:0] enhanced_feature, // enhanced feature register
  input wire logic rts_dtr_sel, // modem control bit2 select
  input wire logic [FIFO_AW-1:0] rx_level, // receive fifo fill
  input wire logic [FIFO_AW-1:0] rx_trigger, // receive trigger level
  input wire logic rx_push, // character moved into fifo
  input wire logic rx_idle, // receive input idle
  input wire logic [CHAR_BITS_W-1:0] char_bits, // bit times per character
  input wire logic [15:0] bit_ticks, // clocks per bit time
  input wire logic [3:0] rx_err_head, // head errors: bits 3..1 read as line status bits 4..2, bit0 only raises the flag
  input wire logic rx_fifo_err, // error somewhere in fifo
  input wire logic overrun, // overrun seen
  input wire logic thr_empty, // holding empty or below tx trigger
  input wire logic tx_all_empty, // fifo and shifter empty
  input wire logic [3:0] modem_delta, // modem status delta bits
  input wire logic [3:0] modem_lines, // modem status pin levels
  input wire logic xon_det, // xon match, one cycle
  input wire logic xoff_det, // xoff match, one cycle
  input wire logic special_det, // special char match, one cycle
  input wire logic rts_out, // auto flow output level
  input wire logic dtr_out, // auto flow output level
  input wire logic cts_pin, // cts input pin, async
  input wire logic dsr_pin, // dsr input pin, async
  input wire logic sleep_exit, // leaving sleep, one cycle
  input wire logic global_rd, // read of global word
  output logic chan_irq, // channel request to global logic
  output logic [3:0] global_code, // encoded pending for global word
  output logic wake_pending // wake-up indicator
);
  import ucil_pkg::*;

  logic [1:0] pin_s; // synchronised cts, dsr
  ucil_sync #(.W(2)) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in({dsr_pin, cts_pin}),
    .sync_out(pin_s)
  );

  // register access decodes; strobes are one cycle so each decode fires once per access
  logic rd_src; // source register read
  logic rd_line; // line status read
  logic rd_modem; // modem status read
  logic rd_flow; // flow character read
  logic wr_mask; // mask register write
  logic enh; // enhanced functions unlocked
  assign rd_src = reg_rd && reg_addr == `UCIL_ADDR_SOURCE;
  assign rd_line = reg_rd && reg_addr == `UCIL_ADDR_LINE;
  assign rd_modem = reg_rd && reg_addr == `UCIL_ADDR_MODEM;
  assign rd_flow = reg_rd && reg_addr == `UCIL_ADDR_FLOWCH;
  assign wr_mask = reg_wr && reg_addr == `UCIL_ADDR_MASK;
  assign enh = enhanced_feature[`UCIL_EFR_ENH];

  // state
  logic [7:0] mask_q, mask_d; // interrupt mask
  logic line_q, line_d; // line status flag
  logic tx_q, tx_d; // transmit ready flag
  logic tx_lvl_q, tx_lvl_d; // previous transmit level, for edge
  logic flow_q, flow_d; // xon/xoff/special flag
  logic spec_q, spec_d; // flag came from special char
  logic [1:0] xch_q, xch_d; // last xon(1)/xoff(0)
  logic hsk_q, hsk_d; // handshake change flag
  logic rto_q, rto_d; // output level last cycle
  logic cti_q, cti_d; // input level last cycle
  logic tmo_q, tmo_d; // timeout flag
  logic [TMO_W-1:0] tcnt_q, tcnt_d; // idle counter
  logic wake_q, wake_d; // wake indicator
  logic [7:0] rdata_q, rdata_d; // read data
  logic line_ev; // errored character arrived
  logic tx_src; // selected transmit empty source
  logic rxd_ev; // receive data condition
  logic hsk_out; // rising edge on selected flow output
  logic hsk_in; // rising edge on selected flow input
  logic sel_out; // rts or dtr, by select bit
  logic sel_in; // cts or dsr, by select bit
  logic [TMO_W-1:0] tmo_lim; // timeout length in clocks
  logic [3:0] gcode_q, gcode_d; // registered global word nibble
  ucil_prio_t top; // highest pending
  logic [5:0] code; // source code
  logic dready; // line status bit0

  // derived events; the error test rides on the push so a head error counts once
  assign line_ev = rx_push && (|rx_err_head);
  assign tx_src = rs485_auto ? tx_all_empty : thr_empty;
  assign rxd_ev = fifo_en ? (rx_level >= rx_trigger) : (rx_level != '0);
  assign dready = rx_level != '0;
  assign sel_out = rts_dtr_sel ? dtr_out : rts_out;
  assign sel_in = rts_dtr_sel ? pin_s[1] : pin_s[0];
  assign hsk_out = enhanced_feature[`UCIL_EFR_AUTO_RTS] && sel_out && !rto_q;
  assign hsk_in = enhanced_feature[`UCIL_EFR_AUTO_CTS] && sel_in && !cti_q;
  // timeout limit: 4 characters plus 12 bit times, in clocks
  // limitation: cut to TMO_W bits, so slow bit rates need a wider counter
  assign tmo_lim = TMO_W'((`UCIL_TMO_CHARS * char_bits + `UCIL_TMO_BITS) * bit_ticks);

  // event flags; set wins over clear in every flag
  always_comb begin
    mask_d = mask_q;
    if (wr_mask) begin
      // low nibble always writable and reserved bit4 stays zero;
      // high bits keep their value until enhanced functions are unlocked
      mask_d = (reg_wdata & `UCIL_MSK_LOW_W) | ((enh ? reg_wdata : mask_q) & `UCIL_MSK_HIGH_W);
    end
    line_d = line_ev ? 1'b1 : (rd_line ? 1'b0 : line_q);
    tx_lvl_d = tx_src;
    // re-arm on entry to ready; a source read acknowledges it
    tx_d = (tx_src && !tx_lvl_q) ? 1'b1 : ((rd_src || !tx_src) ? 1'b0 : tx_q);
    rto_d = sel_out;
    cti_d = sel_in;
    hsk_d = (hsk_out || hsk_in) ? 1'b1 : (rd_modem ? 1'b0 : hsk_q);
    // flow char register self-clears on read; a new match wins
    xch_d = rd_flow ? 2'b00 : xch_q;
    if (xon_det) xch_d = 2'b10;
    if (xoff_det) xch_d = 2'b01;
    // a flow match and its acknowledge in one cycle: the match wins
    flow_d = flow_q;
    spec_d = spec_q;
    if (xon_det || xoff_det || special_det) begin
      flow_d = 1'b1;
      spec_d = special_det && !(xon_det || xoff_det);
    end else if (rd_src || (spec_q && rx_push)) begin
      flow_d = 1'b0;
      spec_d = 1'b0;
    end
    wake_d = sleep_exit ? 1'b1 : (global_rd ? 1'b0 : wake_q);
    // idle timer runs while data sits below trigger
    // it parks at its limit instead of wrapping, so a long idle cannot re-arm it
    tcnt_d = tcnt_q;
    tmo_d = tmo_q;
    if (!fifo_en || !dready || rx_push || !rx_idle || rx_level >= rx_trigger) begin
      tcnt_d = '0;
      if (!dready) tmo_d = 1'b0;
    end else if (tcnt_q >= tmo_lim) begin
      tmo_d = 1'b1;
    end else begin
      tcnt_d = tcnt_q + 1'b1;
    end
  end

  // priority encode of enabled sources
  // fixed order: line, rx data, timeout, transmit, modem, flow char, handshake
  always_comb begin
    if (mask_q[`UCIL_MSK_LINE] && line_q) top = UCIL_P_LINE;
    else if (mask_q[`UCIL_MSK_RX] && rxd_ev) top = UCIL_P_RXD;
    else if (mask_q[`UCIL_MSK_RX] && tmo_q) top = UCIL_P_TMO;
    else if (mask_q[`UCIL_MSK_TX] && tx_q) top = UCIL_P_TX;
    else if (mask_q[`UCIL_MSK_MODEM] && (|modem_delta)) top = UCIL_P_MODEM;
    else if (mask_q[`UCIL_MSK_FLOW] && flow_q) top = UCIL_P_FLOW;
    // either high mask bit enables the shared handshake source
    else if ((mask_q[`UCIL_MSK_RTSO] || mask_q[`UCIL_MSK_CTSI]) && hsk_q) top = UCIL_P_HSK;
    else top = UCIL_P_NONE;
    case (top)
      UCIL_P_LINE: code = `UCIL_SRC_LINE;
      UCIL_P_RXD: code = `UCIL_SRC_RXD;
      UCIL_P_TMO: code = `UCIL_SRC_TMO;
      UCIL_P_TX: code = `UCIL_SRC_TX;
      UCIL_P_MODEM: code = `UCIL_SRC_MODEM;
      UCIL_P_FLOW: code = `UCIL_SRC_FLOW;
      UCIL_P_HSK: code = `UCIL_SRC_HSK;
      default: code = `UCIL_SRC_NONE;
    endcase
  end

  // read data mux; registered one cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      `UCIL_ADDR_MASK: rdata_d = mask_q;
      `UCIL_ADDR_SOURCE: rdata_d = {{2{fifo_en}}, code};
      `UCIL_ADDR_LINE: rdata_d = {rx_fifo_err, tx_all_empty, thr_empty, rx_err_head[3:1], overrun, dready};
      `UCIL_ADDR_MODEM: rdata_d = {modem_lines, modem_delta};
      `UCIL_ADDR_FLOWCH: rdata_d = {6'h00, xch_q};
      // unmapped indices read as zero
      default: rdata_d = 8'h00;
    endcase
  end

  // one register stage for all channel state; reset leaves every flag idle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mask_q <= `UCIL_MASK_RST;
      gcode_q <= '0;
      line_q <= 1'b0;
      tx_q <= 1'b0;
      tx_lvl_q <= 1'b0;
      flow_q <= 1'b0;
      spec_q <= 1'b0;
      xch_q <= 2'b00;
      hsk_q <= 1'b0;
      rto_q <= 1'b0;
      cti_q <= 1'b0;
      tmo_q <= 1'b0;
      tcnt_q <= '0;
      wake_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      mask_q <= mask_d;
      line_q <= line_d;
      tx_q <= tx_d;
      tx_lvl_q <= tx_lvl_d;
      flow_q <= flow_d;
      spec_q <= spec_d;
      xch_q <= xch_d;
      hsk_q <= hsk_d;
      rto_q <= rto_d;
      cti_q <= cti_d;
      tmo_q <= tmo_d;
      tcnt_q <= tcnt_d;
      wake_q <= wake_d;
      rdata_q <= rdata_d;
      gcode_q <= gcode_d;
    end
  end

  // outputs; the global nibble is registered together with the wake bit it carries
  assign gcode_d = {top, wake_d};
  assign reg_rdata = rdata_q;
  assign chan_irq = top != UCIL_P_NONE;
  assign global_code = gcode_q;
  assign wake_pending = wake_q;

  // checks; each label line carries the rule it guards
  // request and encoded source code always agree
  a_irq_matches_code: assert property (@(posedge clk_sys) disable iff (!resetn)
    chan_irq == (code != `UCIL_SRC_NONE))
    else $error("irq disagrees with code");
  // an enabled line error outranks everything
  a_line_wins: assert property (@(posedge clk_sys) disable iff (!resetn)
    line_q && mask_q[`UCIL_MSK_LINE] |-> code == `UCIL_SRC_LINE)
    else $error("line not top");
  // line status read clears its flag unless a new error lands
  a_line_read_clr: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_line && !line_ev |=> !line_q)
    else $error("line read did not clear");
  // an errored character always leaves the flag set
  a_line_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    line_ev |=> line_q)
    else $error("line error lost");
  // high mask bits hold while enhanced functions are locked
  a_hi_mask_lock: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_mask && !enh |=> mask_q[7:5] == $past(mask_q[7:5]))
    else $error("high mask written");
  // reserved mask bit never holds a one
  a_mask4_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    mask_q[4] == 1'b0)
    else $error("reserved mask bit set");
  // sleep exit sets the wake indicator
  a_wake_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    sleep_exit |=> wake_pending)
    else $error("wake lost");
  // a global read clears it when no new exit coincides
  a_wake_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    global_rd && !sleep_exit |=> !wake_pending)
    else $error("wake not cleared");
  // source bits 7:6 mirror fifo enable at the read
  a_src_fifo: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_src |=> reg_rdata[7:6] == {2{$past(fifo_en)}})
    else $error("fifo bits wrong");
  // source bit0 is the inverse of the request at the read
  a_src_bit0: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_src |=> reg_rdata[0] == !$past(chan_irq))
    else $error("source bit0 wrong");
  // data ready bit follows fifo fill at the read
  a_dready_map: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_line |=> reg_rdata[0] == ($past(rx_level) != '0))
    else $error("data ready wrong");
  // source read acknowledges a flow character
  a_flow_read_clr: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_src && !(xon_det || xoff_det || special_det) |=> !flow_q)
    else $error("flow not cleared");
  // a special character flag gives way to the next character
  a_spec_next: assert property (@(posedge clk_sys) disable iff (!resetn)
    spec_q && rx_push && !(xon_det || xoff_det || special_det) |=> !flow_q)
    else $error("special flag kept");
  // source read acknowledges transmit ready
  a_tx_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_src && !(tx_src && !tx_lvl_q) |=> !tx_q)
    else $error("tx not cleared");
  // trigger reached shows receive data unless a line error is on top
  a_rx_level: assert property (@(posedge clk_sys) disable iff (!resetn)
    mask_q[`UCIL_MSK_RX] && fifo_en && rx_level >= rx_trigger && !(mask_q[`UCIL_MSK_LINE] && line_q)
    |-> code == `UCIL_SRC_RXD)
    else $error("rx trigger not shown");
  // idle long enough below trigger sets the timeout
  a_tmo_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    fifo_en && dready && !rx_push && rx_idle && rx_level < rx_trigger && tcnt_q >= tmo_lim |=> tmo_q)
    else $error("timeout not set");
  // an empty fifo ends the timeout
  a_tmo_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    !dready |=> !tmo_q)
    else $error("timeout kept");
  // an enabled modem delta always raises the request
  a_modem_pend: assert property (@(posedge clk_sys) disable iff (!resetn)
    mask_q[`UCIL_MSK_MODEM] && (|modem_delta) |-> chan_irq)
    else $error("modem delta lost");
  // modem status read clears handshake changes unless a new edge lands
  a_hsk_read_clr: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_modem && !(hsk_out || hsk_in) |=> !hsk_q)
    else $error("handshake not cleared");
  // polled mode: none of the five sources under the low mask bits is reported
  a_polled_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
    (mask_q & `UCIL_MSK_LOW_W) == 8'h00 |-> top inside {UCIL_P_NONE, UCIL_P_FLOW, UCIL_P_HSK})
    else $error("polled source reported");
  // global nibble is last cycle's top source with the wake bit
  a_global_code: assert property (@(posedge clk_sys) disable iff (!resetn)
    1'b1 |=> global_code == {$past(top), wake_pending})
    else $error("global code wrong");
  // main scenarios reached
  c_line: cover property (@(posedge clk_sys) disable iff (!resetn) top == UCIL_P_LINE);
  c_tmo: cover property (@(posedge clk_sys) disable iff (!resetn) top == UCIL_P_TMO);
  c_hsk: cover property (@(posedge clk_sys) disable iff (!resetn) top == UCIL_P_HSK);
  c_flow: cover property (@(posedge clk_sys) disable iff (!resetn) top == UCIL_P_FLOW);
  c_wake: cover property (@(posedge clk_sys) disable iff (!resetn) wake_q && global_rd);
endmodule // ucil_channel

// ---- core/ucil_defines.svh ----
`ifndef UCIL_DEFINES_SVH
`define UCIL_DEFINES_SVH
// channel register indices on the a3..a0 address
`define UCIL_ADDR_MASK 4'h1
`define UCIL_ADDR_SOURCE 4'h2
`define UCIL_ADDR_LINE 4'h5
`define UCIL_ADDR_MODEM 4'h6
`define UCIL_ADDR_EFR 4'h9
`define UCIL_ADDR_FLOWCH 4'hc
// mask register fields
`define UCIL_MSK_RX 0
`define UCIL_MSK_TX 1
`define UCIL_MSK_LINE 2
`define UCIL_MSK_MODEM 3
`define UCIL_MSK_FLOW 5
`define UCIL_MSK_RTSO 6
`define UCIL_MSK_CTSI 7
`define UCIL_MSK_LOW_W 8'h0f
`define UCIL_MSK_HIGH_W 8'he0
`define UCIL_MASK_RST 8'h00
// enhanced feature fields
`define UCIL_EFR_ENH 4
`define UCIL_EFR_AUTO_RTS 6
`define UCIL_EFR_AUTO_CTS 7
// source codes, bits 5..0
`define UCIL_SRC_LINE 6'h06
`define UCIL_SRC_RXD 6'h04
`define UCIL_SRC_TMO 6'h0c
`define UCIL_SRC_TX 6'h02
`define UCIL_SRC_MODEM 6'h00
`define UCIL_SRC_FLOW 6'h10
`define UCIL_SRC_HSK 6'h20
`define UCIL_SRC_NONE 6'h01
// timeout: 4 characters plus 12 bit times
`define UCIL_TMO_CHARS 4
`define UCIL_TMO_BITS 12
`define UCIL_SYNC_RST 3'h0
`endif

// ---- core/ucil_pkg.sv ----
package ucil_pkg;
  // pending source: none first, then the sources from highest priority down
  typedef enum logic [2:0] {
    UCIL_P_NONE = 3'b000,
    UCIL_P_LINE = 3'b001,
    UCIL_P_RXD = 3'b010,
    UCIL_P_TMO = 3'b011,
    UCIL_P_TX = 3'b100,
    UCIL_P_MODEM = 3'b101,
    UCIL_P_FLOW = 3'b110,
    UCIL_P_HSK = 3'b111
  } ucil_prio_t;
endpackage

// ---- core/ucil_sync.sv ----
`include "ucil_defines.svh"
// three-stage input synchroniser with agreement filter
module ucil_sync #(
  parameter int W = 2
) (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic [W-1:0] async_in, // raw pin levels
  output logic [W-1:0] sync_out // filtered level
);
  logic [2:0] st_q [W]; // per-bit stages
  logic [2:0] st_d [W]; // next stages
  logic out_q [W]; // filtered output, one element per bit so each loop pass owns its own
  logic out_d [W]; // next output
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // shift in; stage0 feeds only stage1
      always_comb begin
        st_d[g] = {st_q[g][1:0], async_in[g]};
        // accept change when stages 1 and 2 agree
        out_d[g] = (st_q[g][1] == st_q[g][2]) ? st_q[g][1] : out_q[g];
      end
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          st_q[g] <= `UCIL_SYNC_RST;
          out_q[g] <= 1'b0;
        end else begin
          st_q[g] <= st_d[g];
          out_q[g] <= out_d[g];
        end
      end
      assign sync_out[g] = out_q[g];
    end
  endgenerate
endmodule // ucil_sync

// ---- sim/ucil_host_model.sv ----
// host side of the channel register port, one byte per access
module ucil_host_model (
  input wire logic clk_sys, // system clock
  output logic [3:0] reg_addr, // register index
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  output logic [7:0] reg_wdata, // write data
  input wire logic [7:0] reg_rdata // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // one-cycle write; data inverted after so no one leans on a stale byte
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule // ucil_host_model

// ---- sim/uart_channel_interrupt_logic_tb.sv ----
`include "ucil_defines.svh"
module uart_channel_interrupt_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ucil_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0;
  logic fifo_en = 1'b0, rs485_auto = 1'b0, rts_dtr_sel = 1'b0, rx_push = 1'b0, rx_idle = 1'b0;
  logic [7:0] enhanced_feature = 8'h00;
  logic [6:0] rx_level = 7'h00, rx_trigger = 7'h04;
  logic [3:0] char_bits = 4'h2, rx_err_head = 4'h0, modem_delta = 4'h0, modem_lines = 4'h0;
  logic [15:0] bit_ticks = 16'h0002;
  logic rx_fifo_err = 1'b0, overrun = 1'b0, thr_empty = 1'b0, tx_all_empty = 1'b0;
  logic xon_det = 1'b0, xoff_det = 1'b0, special_det = 1'b0, rts_out = 1'b0, dtr_out = 1'b0;
  logic cts_pin = 1'b0, dsr_pin = 1'b0, sleep_exit = 1'b0, global_rd = 1'b0;
  logic [3:0] reg_addr;
  logic reg_wr, reg_rd, chan_irq, wake_pending;
  logic [7:0] reg_wdata, reg_rdata, junk;
  logic [3:0] global_code;
  int n_fail = 0;
  int checks_done = 0;
  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;
  ucil_host_model i_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  ucil_channel i_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fifo_en(fifo_en),
    .rs485_auto(rs485_auto), .enhanced_feature(enhanced_feature), .rts_dtr_sel(rts_dtr_sel),
    .rx_level(rx_level), .rx_trigger(rx_trigger), .rx_push(rx_push), .rx_idle(rx_idle),
    .char_bits(char_bits), .bit_ticks(bit_ticks), .rx_err_head(rx_err_head), .rx_fifo_err(rx_fifo_err),
    .overrun(overrun), .thr_empty(thr_empty), .tx_all_empty(tx_all_empty), .modem_delta(modem_delta),
    .modem_lines(modem_lines), .xon_det(xon_det), .xoff_det(xoff_det), .special_det(special_det),
    .rts_out(rts_out), .dtr_out(dtr_out), .cts_pin(cts_pin), .dsr_pin(dsr_pin), .sleep_exit(sleep_exit),
    .global_rd(global_rd), .chan_irq(chan_irq), .global_code(global_code), .wake_pending(wake_pending));
  // verdict and end of run
  task automatic results();
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // compare one byte, case equality so unknowns never match
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // read a register and compare it
  task automatic rc(input logic [3:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    i_host.rd(a, d);
    chk(nm, e, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // bounded wait for the channel request; running out ends the run
  task automatic wait_irq(input int n);
    for (int i = 0; i < n && chan_irq !== 1'b1; i++) @(negedge clk_sys);
    chk("chan_irq", 8'h01, {7'h00, chan_irq});
    if (chan_irq !== 1'b1) results();
  endtask
  // fifo enabled, so source bits 7:6 read as ones from here on
  function automatic logic [7:0] src(input logic [5:0] c);
    return {2'b11, c};
  endfunction
  // watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    results();
  end
  initial begin
    cyc(12);
    resetn = 1'b1;
    rc(`UCIL_ADDR_SOURCE, 8'h01, "source");
    rc(`UCIL_ADDR_MASK, `UCIL_MASK_RST, "mask");
    i_host.wr(`UCIL_ADDR_MASK, 8'hff);
    rc(`UCIL_ADDR_MASK, 8'h0f, "mask");
    enhanced_feature = 8'hd0;
    i_host.wr(`UCIL_ADDR_MASK, 8'hff);
    rc(`UCIL_ADDR_MASK, 8'hef, "mask");
    fifo_en = 1'b1;
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_NONE), "source");
    // receive trigger, then a line error on top of it
    rx_level = 7'h04;
    cyc(1);
    chk("chan_irq", 8'h01, {7'h00, chan_irq});
    chk("global_code", {5'h00, UCIL_P_RXD}, {5'h00, global_code[3:1]});
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_RXD), "source");
    // the error rides on a pushed character
    rx_err_head = 4'h2;
    rx_push = 1'b1;
    cyc(1);
    rx_push = 1'b0;
    rx_err_head = 4'h0;
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_LINE), "source");
    i_host.rd(`UCIL_ADDR_LINE, junk);
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_RXD), "source");
    rx_level = 7'h03;
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_NONE), "source");
    // timeout is (4*2+12)*2 = 40 clocks of idle below trigger
    rx_level = 7'h01;
    rx_idle = 1'b1;
    cyc(30);
    chk("chan_irq", 8'h00, {7'h00, chan_irq});
    wait_irq(40);
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_TMO), "source");
    rx_level = 7'h00;
    rx_idle = 1'b0;
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_NONE), "source");
    // transmit source in both half-duplex settings
    thr_empty = 1'b1;
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_TX), "source");
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_NONE), "source");
    thr_empty = 1'b0;
    cyc(1);
    rs485_auto = 1'b1;
    tx_all_empty = 1'b1;
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_TX), "source");
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_NONE), "source");
    tx_all_empty = 1'b0;
    thr_empty = 1'b1;
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_NONE), "source");
    // modem delta
    modem_delta = 4'h8;
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_MODEM), "source");
    modem_delta = 4'h0;
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_NONE), "source");
    // flow characters: xoff then xon, last one readable
    xoff_det = 1'b1;
    cyc(1);
    xoff_det = 1'b0;
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_FLOW), "source");
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_NONE), "source");
    rc(`UCIL_ADDR_FLOWCH, 8'h01, "flow_char");
    xon_det = 1'b1;
    cyc(1);
    xon_det = 1'b0;
    rc(`UCIL_ADDR_FLOWCH, 8'h02, "flow_char");
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_FLOW), "source");
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_NONE), "source");
    // special character cleared by the next received character
    special_det = 1'b1;
    cyc(1);
    special_det = 1'b0;
    chk("chan_irq", 8'h01, {7'h00, chan_irq});
    rx_push = 1'b1;
    cyc(1);
    rx_push = 1'b0;
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_NONE), "source");
    // handshake output and input rising
    rts_out = 1'b1;
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_HSK), "source");
    i_host.rd(`UCIL_ADDR_MODEM, junk);
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_NONE), "source");
    cts_pin = 1'b1;
    wait_irq(10);
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_HSK), "source");
    i_host.rd(`UCIL_ADDR_MODEM, junk);
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_NONE), "source");
    // wake indicator set on sleep exit, cleared by global read
    sleep_exit = 1'b1;
    cyc(1);
    sleep_exit = 1'b0;
    chk("wake_pending", 8'h01, {7'h00, wake_pending});
    chk("global_wake", 8'h01, {7'h00, global_code[0]});
    global_rd = 1'b1;
    cyc(1);
    global_rd = 1'b0;
    chk("wake_pending", 8'h00, {7'h00, wake_pending});
    // polled mode: low mask bits clear, trigger reached but no request
    i_host.wr(`UCIL_ADDR_MASK, 8'he0);
    rx_level = 7'h04;
    cyc(1);
    chk("chan_irq", 8'h00, {7'h00, chan_irq});
    rc(`UCIL_ADDR_SOURCE, src(`UCIL_SRC_NONE), "source");
    // line and modem status stay readable in polled mode
    rx_fifo_err = 1'b1;
    overrun = 1'b1;
    rx_err_head = 4'h8;
    modem_lines = 4'ha;
    rc(`UCIL_ADDR_LINE, 8'hb3, "line_status");
    rc(`UCIL_ADDR_MODEM, 8'ha0, "modem_status");
    results();
  end
endmodule // uart_channel_interrupt_logic_tb
